// ==== verilog/psram_link_cfg.svh ====
// offsets, field positions, reset values and timing counts of the link
`ifndef PSRAM_LINK_CFG_SVH
`define PSRAM_LINK_CFG_SVH
// ------------------------------------------------------------
// host register map (byte addresses)
// ------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_STATUS 8'h08
`define REG_BUF_HI 3'h1
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CTRL_START 0
`define CTRL_WRITE 1
`define CTRL_ROWSTOP 2
`define CTRL_LEN_LSB 4
`define CTRL_LEN_MSB 6
`define STAT_BUSY 0
`define STAT_TRUNC 1
`define STAT_TIMEOUT 2
`define ADDR_RESET 16'h0000
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_SYS_NS 10
`define MAX_SELECT_LOW_NS 4000
`define MAX_SELECT_LOW_CYC (`MAX_SELECT_LOW_NS / `CLK_SYS_NS)
`define MIN_SELECT_HIGH_GAP_NS 5
`define MIN_SELECT_HIGH_GAP_CYC \
   ((`MIN_SELECT_HIGH_GAP_NS + `CLK_SYS_NS - 1) / `CLK_SYS_NS)
`define REFRESH_HIGH_NS 15
`define REFRESH_HIGH_CYC (`REFRESH_HIGH_NS / `CLK_SYS_NS + 1)
`endif

// ==== verilog/psram_link_pkg.sv ====
// types shared by both ends of the muxed psram link
package psram_link_pkg;
   typedef enum logic [2:0] {H_IDLE, H_ADDR, H_DATA, H_DRAIN, H_GAP} hstate_t;
   typedef enum logic [1:0] {D_IDLE, D_WAIT, D_DATA, D_DONE} dstate_t;
endpackage

// ==== verilog/psram_link_if.sv ====
// pins between host controller and psram device
interface psram_link_if;
   logic clkLink;
   logic ceN;
   logic advN;
   logic weN;
   logic waitN;
   logic [15:0] hostAdq;
   logic hostAdqOeN;
   logic [15:0] devAdq;
   logic devAdqOeN;
   logic [15:0] adqBus;
   // wire level of the shared bus; nobody driving reads as zero
   assign adqBus = !hostAdqOeN ? hostAdq :
                   (!devAdqOeN ? devAdq : 16'h0000);
   modport host (output clkLink, ceN, advN, weN, hostAdq, hostAdqOeN,
                 input waitN, adqBus);
   modport device (input clkLink, ceN, advN, weN, adqBus,
                   output devAdq, devAdqOeN, waitN);
endinterface

// ==== verilog/psram_device_end.sv ====
// psram device end: burst sequencing with stall indicator
`include "psram_link_cfg.svh"
module psram_device_end
   import psram_link_pkg::*;
#(
   parameter int MEM_WORDS = 256,
   parameter int ROW_WORDS = 128
) (
   input wire logic rst_b,
   input wire logic [2:0] latencyCode,
   input wire logic [5:0] burstWords,
   output logic inBurst,
   psram_link_if.device link
);
   localparam int MB = $clog2(MEM_WORDS);
   localparam int RB = $clog2(ROW_WORDS);

   logic [15:0] mem [MEM_WORDS];
   logic [2:0] lcMeta, lcSync;
   logic [5:0] blMeta, blSync;
   dstate_t state, next_state;
   logic [15:0] addr, next_addr;
   logic [5:0] words, next_words;
   logic [2:0] waitCnt, next_waitCnt;
   logic isWrite, next_isWrite;
   logic waitN, next_waitN;
   logic [15:0] adqOut, next_adqOut;
   logic adqOeN, next_adqOeN;
   logic next_inBurst;
   logic [2:0] lc1;
   logic memWe;

   // ------------------------------------------------------------
   // configuration crossing
   // ------------------------------------------------------------
   // quasi-static settings; change only while the select is high
   always_ff @(posedge link.clkLink or negedge rst_b) begin
      if (!rst_b) begin
         lcMeta <= 3'h0;
         lcSync <= 3'h0;
         blMeta <= 6'h00;
         blSync <= 6'h00;
      end else begin
         lcMeta <= latencyCode;
         lcSync <= lcMeta;
         blMeta <= burstWords;
         blSync <= blMeta;
      end
   end

   // ------------------------------------------------------------
   // burst sequencer
   // ------------------------------------------------------------
   // a code of zero would wrap the count to an eight-cycle stall, treat it as one
   assign lc1 = (lcSync == 3'h0) ? 3'h1 : lcSync;
   assign memWe = !link.ceN && link.advN && state == D_DATA && isWrite;

   always_comb begin
      next_state = state;
      next_addr = addr;
      next_words = words;
      next_waitCnt = waitCnt;
      next_isWrite = isWrite;
      next_waitN = waitN;
      next_adqOut = adqOut;
      next_adqOeN = adqOeN;
      if (link.ceN) begin
         next_state = D_IDLE;
         next_waitN = 1'b1;
         next_adqOeN = 1'b1;
      end else if (!link.advN) begin
         // new address restarts even inside a fixed-latency burst
         next_addr = link.adqBus;
         next_isWrite = !link.weN;
         next_words = 6'h00;
         next_waitCnt = lc1;
         next_waitN = 1'b0;
         next_adqOeN = 1'b1;
         next_state = D_WAIT;
      end else begin
         case (state)
            D_WAIT: begin
               if (waitCnt == 3'h1) begin
                  // first word at clock code plus one
                  next_waitN = 1'b1;
                  next_state = D_DATA;
                  if (!isWrite) begin
                     next_adqOut = mem[addr[MB-1:0]];
                     next_adqOeN = 1'b0;
                  end
               end else begin
                  next_waitCnt = waitCnt - 3'h1;
               end
            end
            D_DATA: begin
               next_words = words + 6'h01;
               next_addr = addr + 16'h0001;
               if (blSync != 6'h00 && words == blSync - 6'h01) begin
                  // stall stays released past the burst end
                  next_state = D_DONE;
                  next_adqOeN = 1'b1;
               end else if (&addr[RB-1:0]) begin
                  next_state = D_WAIT;
                  next_waitCnt = lc1;
                  next_waitN = 1'b0;
                  next_adqOeN = 1'b1;
               end else if (!isWrite) begin
                  next_adqOut = mem[next_addr[MB-1:0]];
               end
            end
            D_DONE: begin
               next_waitN = 1'b1;
            end
            default: begin
               next_state = D_IDLE;
            end
         endcase
      end
      next_inBurst = next_state != D_IDLE;
   end

   always_ff @(posedge link.clkLink or negedge rst_b) begin
      if (!rst_b) begin
         state <= D_IDLE;
         addr <= 16'h0000;
         words <= 6'h00;
         waitCnt <= 3'h0;
         isWrite <= 1'b0;
         waitN <= 1'b1;
         adqOut <= 16'h0000;
         adqOeN <= 1'b1;
         inBurst <= 1'b0;
      end else begin
         state <= next_state;
         addr <= next_addr;
         words <= next_words;
         waitCnt <= next_waitCnt;
         isWrite <= next_isWrite;
         waitN <= next_waitN;
         adqOut <= next_adqOut;
         adqOeN <= next_adqOeN;
         inBurst <= next_inBurst;
      end
   end

   // array has no reset; contents are undefined until written
   always_ff @(posedge link.clkLink) begin
      if (memWe) begin
         mem[addr[MB-1:0]] <= link.adqBus;
      end
   end

   assign link.waitN = waitN;
   assign link.devAdq = adqOut;
   assign link.devAdqOeN = adqOeN;
endmodule

// ==== verilog/psram_host_end.sv ====
// host controller end: apb registers, link clock and burst sequencing
`include "psram_link_cfg.svh"
// Contract
// - device keeps stall released after burst end
// - host ignores bus after last read word
// - read row end: raise select within one clock
// - write row end: raise select within one clock
// - write stall lasts latency code cycles
// - latency code two gives three clocks
// - write: select high before edge after last
// - refresh opportunity within every low interval
// - select high between async and variable bursts
// - fixed-latency switch restarts on address strobe
// - synchronous mode needs 5 ns select-high gap
// - otherwise gap needed after select-ended writes
// - row crossing stalls latency code cycles
// - select and write strobe low at most 4 us
// - latency code four gives five clocks
module psram_host_end
   import psram_link_pkg::*;
#(
   parameter int LINK_DIV = 8,
   parameter int BUF_WORDS = 8
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   psram_link_if.host link
);
   localparam logic [7:0] HALF = 8'(LINK_DIV / 2 - 1);
   localparam logic [15:0] MAX_LOW = 16'(`MAX_SELECT_LOW_CYC - 2 * LINK_DIV);
   localparam logic [7:0] GAP_MIN = 8'(`MIN_SELECT_HIGH_GAP_CYC);
   localparam logic [7:0] REF_MIN = 8'(`REFRESH_HIGH_CYC);

   logic [7:0] divCnt, next_divCnt;
   logic clkOut, next_clkOut;
   logic fallTick;
   logic waitMeta, waitSync;
   logic [15:0] adqMeta, adqSync;
   hstate_t state, next_state;
   logic [15:0] buffer [BUF_WORDS];
   logic [15:0] next_buffer [BUF_WORDS];
   logic ctrlWrite, next_ctrlWrite;
   logic rowStop, next_rowStop;
   logic [2:0] lenM1, next_lenM1;
   logic [15:0] addrReg, next_addrReg;
   logic pending, next_pending;
   logic trunc, next_trunc;
   logic timeout, next_timeout;
   logic [2:0] wordCnt, next_wordCnt;
   logic [15:0] lowCnt, next_lowCnt;
   logic [7:0] gapCnt, next_gapCnt;
   logic ceN, next_ceN;
   logic advN, next_advN;
   logic weN, next_weN;
   logic [15:0] adqOut, next_adqOut;
   logic adqOeN, next_adqOeN;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr;
   logic apbSetup, apbDone, bufHit, hit;
   logic [2:0] bufIdx;

   // ------------------------------------------------------------
   // link clock divider
   // ------------------------------------------------------------
   // pins change with the falling link edge, so the device sees
   // half a period of setup at its rising edge
   always_comb begin
      next_divCnt = divCnt + 8'h01;
      next_clkOut = clkOut;
      if (divCnt == HALF) begin
         next_divCnt = 8'h00;
         next_clkOut = !clkOut;
      end
   end
   assign fallTick = divCnt == HALF && clkOut;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         divCnt <= 8'h00;
         clkOut <= 1'b0;
      end else begin
         divCnt <= next_divCnt;
         clkOut <= next_clkOut;
      end
   end

   // ------------------------------------------------------------
   // device outputs into clk_sys
   // ------------------------------------------------------------
   // bus word is stable for half a link period before it is used
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         waitMeta <= 1'b1;
         waitSync <= 1'b1;
         adqMeta <= 16'h0000;
         adqSync <= 16'h0000;
      end else begin
         waitMeta <= link.waitN;
         waitSync <= waitMeta;
         adqMeta <= link.adqBus;
         adqSync <= adqMeta;
      end
   end

   // ------------------------------------------------------------
   // apb slave, registers and burst sequencer
   // ------------------------------------------------------------
   assign apbSetup = psel && !penable;
   assign apbDone = psel && penable && pready;
   assign bufIdx = paddr[4:2];
   assign bufHit = paddr[7:5] == `REG_BUF_HI && paddr[1:0] == 2'h0 &&
                   32'(bufIdx) < BUF_WORDS;
   assign hit = paddr == `REG_CTRL || paddr == `REG_ADDR ||
                paddr == `REG_STATUS || bufHit;

   always_comb begin
      next_state = state;
      next_buffer = buffer;
      next_ctrlWrite = ctrlWrite;
      next_rowStop = rowStop;
      next_lenM1 = lenM1;
      next_addrReg = addrReg;
      next_pending = pending;
      next_trunc = trunc;
      next_timeout = timeout;
      next_wordCnt = wordCnt;
      next_gapCnt = gapCnt;
      next_ceN = ceN;
      next_advN = advN;
      next_weN = weN;
      next_adqOut = adqOut;
      next_adqOeN = adqOeN;
      next_pready = apbSetup;
      next_pslverr = apbSetup && !hit;
      next_prdata = 32'h0000_0000;
      // select-low time, counted to cap every frame
      next_lowCnt = ceN ? 16'h0000 : lowCnt + 16'h0001;
      if (apbSetup) begin
         if (paddr == `REG_CTRL) begin
            next_prdata[`CTRL_START] = pending;
            next_prdata[`CTRL_WRITE] = ctrlWrite;
            next_prdata[`CTRL_ROWSTOP] = rowStop;
            next_prdata[`CTRL_LEN_MSB:`CTRL_LEN_LSB] = lenM1;
         end else if (paddr == `REG_ADDR) begin
            next_prdata[15:0] = addrReg;
         end else if (paddr == `REG_STATUS) begin
            next_prdata[`STAT_BUSY] = pending || state != H_IDLE;
            next_prdata[`STAT_TRUNC] = trunc;
            next_prdata[`STAT_TIMEOUT] = timeout;
         end else if (bufHit) begin
            next_prdata[15:0] = buffer[bufIdx];
         end
      end
      // settings are ignored while a burst is queued or running
      if (apbDone && pwrite && state == H_IDLE && !pending) begin
         if (paddr == `REG_CTRL) begin
            next_ctrlWrite = pwdata[`CTRL_WRITE];
            next_rowStop = pwdata[`CTRL_ROWSTOP];
            next_lenM1 = pwdata[`CTRL_LEN_MSB:`CTRL_LEN_LSB];
            if (pwdata[`CTRL_START]) begin
               next_pending = 1'b1;
               next_trunc = 1'b0;
               next_timeout = 1'b0;
            end
         end else if (paddr == `REG_ADDR) begin
            next_addrReg = pwdata[15:0];
         end else if (bufHit) begin
            next_buffer[bufIdx] = pwdata[15:0];
         end
      end
      if (state == H_GAP && gapCnt != 8'hFF) begin
         next_gapCnt = gapCnt + 8'h01;
      end
      if (fallTick) begin
         case (state)
            H_IDLE: begin
               if (pending) begin
                  next_pending = 1'b0;
                  next_ceN = 1'b0;
                  next_advN = 1'b0;
                  next_weN = !ctrlWrite;
                  next_adqOut = addrReg;
                  next_adqOeN = 1'b0;
                  next_wordCnt = 3'h0;
                  next_state = H_ADDR;
               end
            end
            H_ADDR: begin
               next_advN = 1'b1;
               next_adqOeN = 1'b1;
               next_state = H_DATA;
            end
            H_DATA: begin
               if (lowCnt >= MAX_LOW) begin
                  next_timeout = 1'b1;
                  next_state = H_GAP;
               end else if (!waitSync) begin
                  // stall mid-burst is a row end: leave at once when rowStop is set, else wait it out
                  if (wordCnt != 3'h0 && rowStop) begin
                     next_trunc = 1'b1;
                     next_state = H_GAP;
                  end
               end else if (ctrlWrite) begin
                  next_adqOut = buffer[wordCnt];
                  next_adqOeN = 1'b0;
                  next_wordCnt = wordCnt + 3'h1;
                  if (wordCnt == lenM1) begin
                     next_state = H_DRAIN;
                  end
               end else begin
                  next_buffer[wordCnt] = adqSync;
                  next_wordCnt = wordCnt + 3'h1;
                  if (wordCnt == lenM1) begin
                     next_state = H_GAP;
                  end
               end
            end
            H_DRAIN: begin
               next_state = H_GAP;
            end
            H_GAP: begin
               // gap spans a rising edge and exceeds 15 ns
               if (gapCnt >= GAP_MIN && gapCnt >= REF_MIN) begin
                  next_state = H_IDLE;
               end
            end
            default: begin
               next_state = H_GAP;
            end
         endcase
         // every frame closes with select high
         if (next_state == H_GAP && state != H_GAP) begin
            next_ceN = 1'b1;
            next_advN = 1'b1;
            next_weN = 1'b1;
            next_adqOeN = 1'b1;
            next_gapCnt = 8'h00;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state <= H_IDLE;
         for (int i = 0; i < BUF_WORDS; i++) begin
            buffer[i] <= 16'h0000;
         end
         ctrlWrite <= 1'b0;
         rowStop <= 1'b0;
         lenM1 <= 3'h0;
         addrReg <= `ADDR_RESET;
         pending <= 1'b0;
         trunc <= 1'b0;
         timeout <= 1'b0;
         wordCnt <= 3'h0;
         lowCnt <= 16'h0000;
         gapCnt <= 8'h00;
         ceN <= 1'b1;
         advN <= 1'b1;
         weN <= 1'b1;
         adqOut <= 16'h0000;
         adqOeN <= 1'b1;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         state <= next_state;
         buffer <= next_buffer;
         ctrlWrite <= next_ctrlWrite;
         rowStop <= next_rowStop;
         lenM1 <= next_lenM1;
         addrReg <= next_addrReg;
         pending <= next_pending;
         trunc <= next_trunc;
         timeout <= next_timeout;
         wordCnt <= next_wordCnt;
         lowCnt <= next_lowCnt;
         gapCnt <= next_gapCnt;
         ceN <= next_ceN;
         advN <= next_advN;
         weN <= next_weN;
         adqOut <= next_adqOut;
         adqOeN <= next_adqOeN;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   assign link.clkLink = clkOut;
   assign link.ceN = ceN;
   assign link.advN = advN;
   assign link.weN = weN;
   assign link.hostAdq = adqOut;
   assign link.hostAdqOeN = adqOeN;
endmodule

// ==== verification/psram_link_properties.sv ====
// link pin checks for the muxed psram host and device ends
`include "psram_link_cfg.svh"
module psram_link_properties (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic rstLinkB,
   input wire logic clkLink,
   input wire logic ceN,
   input wire logic advN,
   input wire logic weN,
   input wire logic waitN,
   input wire logic hostAdqOeN,
   input wire logic devAdqOeN,
   input wire logic [2:0] latencyCode
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LOW_CAP = `MAX_SELECT_LOW_CYC;
   logic [2:0] effLc;
   logic [3:0] lowRun;
   logic [3:0] next_lowRun;
   logic [9:0] lowCnt;
   logic [9:0] next_lowCnt;
   // a zero code behaves as one
   assign effLc = (latencyCode == 3'h0) ? 3'h1 : latencyCode;
   // length of the current stall run, in link edges
   always_comb next_lowRun = waitN ? 4'h0 : lowRun + 4'h1;
   always_ff @(posedge clkLink or negedge rstLinkB) begin
      if (!rstLinkB) lowRun <= 4'h0;
      else lowRun <= next_lowRun;
   end
   // select-low time in system cycles, refresh needs a bound on it
   always_comb next_lowCnt = ceN ? 10'h000 : lowCnt + 10'h001;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) lowCnt <= 10'h000;
      else lowCnt <= next_lowCnt;
   end
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   sequence addrTake;
      !ceN && !advN;
   endsequence
   sequence stallTwo;
      !waitN [*2] ##1 waitN;
   endsequence
   sequence stallFour;
      !waitN [*4] ##1 waitN;
   endsequence
   a_lc_two_wait: assert property (@(posedge clkLink)
      disable iff (!rstLinkB) addrTake ##0 (effLc == 3'h2) |=> stallTwo)
      else $error("latency code two stall length wrong");
   a_lc_four_wait: assert property (@(posedge clkLink)
      disable iff (!rstLinkB) addrTake ##0 (effLc == 3'h4) |=> stallFour)
      else $error("latency code four stall length wrong");
   a_stall_run_length: assert property (@(posedge clkLink)
      disable iff (!rstLinkB)
      ($rose(waitN) && !ceN && !$past(ceN)) |-> (lowRun == {1'b0, effLc}))
      else $error("stall run differs from latency code");
   a_data_on_release: assert property (@(posedge clkLink)
      disable iff (!rstLinkB)
      ($rose(waitN) && !ceN && !$past(ceN)) |-> (devAdqOeN == !weN))
      else $error("device bus drive wrong when stall ends");
   a_select_abort: assert property (@(posedge clkLink)
      disable iff (!rstLinkB) ceN |=> (devAdqOeN && waitN))
      else $error("device still active after select high");
   a_strobe_one_period: assert property (@(posedge clkLink)
      disable iff (!rstLinkB) $fell(advN) |=> advN)
      else $error("address strobe longer than one period");
   a_no_bus_fight: assert property (@(posedge clk_sys)
      disable iff (!rst_b) !(!hostAdqOeN && !devAdqOeN))
      else $error("both ends drive the bus");
   a_select_gap: assert property (@(posedge clk_sys)
      disable iff (!rst_b) $rose(ceN) |-> ceN [*2])
      else $error("select high gap too short");
   a_low_time_cap: assert property (@(posedge clk_sys)
      disable iff (!rst_b) lowCnt <= LOW_CAP)
      else $error("select low too long");
   a_strobe_in_frame: assert property (@(posedge clk_sys)
      disable iff (!rst_b) !weN |-> !ceN)
      else $error("write strobe low outside a frame");
endmodule

// ==== verification/muxed_psram_burst_bus_sequencing_tb.sv ====
// self-checking bench: host and device ends joined over the link
`include "psram_link_cfg.svh"
module muxed_psram_burst_bus_sequencing_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic rstLinkB = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [2:0] latencyCode = 3'h2;
   logic [5:0] burstWords = 6'h04;
   logic inBurst;
   int err_count = 0;
   int comparisons = 0;
   logic [31:0] seed = 32'h71BD;
   logic [15:0] expWord [8];
   psram_link_if link();
   always #5 clk_sys = ~clk_sys;
   psram_host_end i_psram_host_end (.clk_sys(clk_sys), .rst_b(rst_b),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link.host));
   psram_device_end i_psram_device_end (.rst_b(rstLinkB),
      .latencyCode(latencyCode), .burstWords(burstWords),
      .inBurst(inBurst), .link(link.device));
   psram_link_properties i_psram_link_properties (.clk_sys(clk_sys),
      .rst_b(rst_b), .rstLinkB(rstLinkB), .clkLink(link.clkLink),
      .ceN(link.ceN), .advN(link.advN), .weN(link.weN),
      .waitN(link.waitN), .hostAdqOeN(link.hostAdqOeN),
      .devAdqOeN(link.devAdqOeN), .latencyCode(latencyCode));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic results();
      if (err_count == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // one apb transfer; waits for pready, bounded
   task automatic apb(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int n;
      n = 0;
      @(posedge clk_sys);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      penable <= 1'b0;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (n >= 40) check({31'h0, pready}, 32'h1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(a, 1'b1, d, r, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(a, 1'b0, 32'h0, r, e);
   endtask
   // buffer load, plain or inverted so a read must really refill it
   task automatic loadBuf(input int len, input logic inv);
      for (int i = 0; i < len; i++) begin
         wr(8'h20 + 8'(4 * i), {16'h0, inv ? ~expWord[i] : expWord[i]});
      end
   endtask
   // compare the first n buffer words with what was written
   task automatic cmpBuf(input int n);
      logic [31:0] r;
      for (int i = 0; i < n; i++) begin
         rd(8'h20 + 8'(4 * i), r);
         check(r, {16'h0, expWord[i]});
      end
   endtask
   // one burst; a write to ADDR while busy must be dropped
   task automatic burst(input logic w, input logic stop, input logic [2:0] lc,
                        input int len, input logic [7:0] a);
      logic [31:0] s;
      logic tr;
      tr = stop && ((int'(a[6:0]) + len) > 128);
      @(posedge clk_sys);
      latencyCode <= lc;
      burstWords <= 6'(len);
      repeat (40) @(posedge clk_sys);
      wr(`REG_ADDR, {24'h0, a});
      wr(`REG_CTRL, {25'h0, 3'(len - 1), 1'b0, stop, w, 1'b1});
      wr(`REG_ADDR, 32'h0000FFFF);
      for (int n = 0; n < 400; n++) begin
         rd(`REG_STATUS, s);
         if (s[0] === 1'b0) break;
      end
      check(s & 32'h7, {30'h0, tr, 1'b0});
      // select has been high across a link edge, so the device is idle
      check({31'h0, inBurst}, 32'h0);
      rd(`REG_ADDR, s);
      check(s, {24'h0, a});
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] r;
      logic e;
      logic [7:0] a;
      logic [2:0] lc;
      int len;
      int keep;
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (40) @(posedge clk_sys);
      rstLinkB <= 1'b1;
      rd(`REG_CTRL, r);
      check(r, 32'h0);
      rd(`REG_ADDR, r);
      check(r, {16'h0, `ADDR_RESET});
      rd(`REG_STATUS, r);
      check(r, 32'h0);
      apb(8'h0C, 1'b0, 32'h0, r, e);
      check(r, 32'h0);
      check({31'h0, e}, 32'h1);
      for (int k = 0; k < 12; k++) begin
         lc = (k == 0) ? 3'h2 : (k == 1) ? 3'h4 : 3'(rnd() % 7) + 3'h1;
         len = (k == 2) ? 4 : int'(rnd() % 8) + 1;
         a = (k == 2) ? 8'h7E : 8'(rnd() % (257 - len));
         for (int i = 0; i < 8; i++) expWord[i] = rnd() & 32'hFFFF;
         loadBuf(len, 1'b0);
         burst(1'b1, 1'b0, lc, len, a);
         loadBuf(len, 1'b1);
         burst(1'b0, 1'b0, lc, len, a);
         cmpBuf(len);
         // row stop keeps only the words up to the row end
         keep = 128 - int'(a[6:0]);
         loadBuf(len, 1'b1);
         burst(1'b0, 1'b1, lc, len, a);
         cmpBuf(keep < len ? keep : len);
         burst(1'b1, 1'b1, lc, len, a);
      end
      results();
   end
   // hang guard, well above the longest expected run
   initial begin
      // about 8k cycles expected; the guard stops the run at 50k cycles
      #500000;
      err_count++;
      results();
   end
endmodule
